// [include/pcrs_pkg.sv]
// Constants and types shared by the program counter and return stack.
// Assumes one core clock, a synchronous active-low reset and a sequencer
// that issues at most one flow command and one special-register access
// per cycle.
//
// What this block does
// R1 - Counter is 21 bits in three bytes.
// R2 - Only low byte is software readable and writable.
// R3 - High and upper bytes load only through latches.
// R4 - Low byte write loads upper bytes from latches.
// R5 - Low byte read copies upper bytes to latches.
// R6 - Counter bit zero is always zero.
// R7 - Sequential fetch advances counter by two.
// R8 - Calls, jumps, branches load counter without latches.
// R9 - Calls and interrupts push; 31 levels nest.
// R10 - Return, literal return, interrupt return pop.
// R11 - Calls and returns leave latches unchanged.
// R12 - Stack is dedicated 31 by 21 memory, 5-bit pointer.
// R13 - Push increments pointer, then writes return address.
// R14 - Pop reads selected entry, then decrements pointer.
// R15 - Reset clears pointer; zero has no entry.
// R16 - Overflow and underflow reported as status bits.
// R17 - Software reads, writes pointer and top entry.
// R18 - Three top bytes access only the selected entry.
// R19 - Software masks interrupts while touching the stack.
// R20 - Push at 31 overflows; pop at 0 underflows.

package pcrs_pkg;

   // ---------------------------------------------------------------
   // Widths and depths
   // ---------------------------------------------------------------
   localparam int PCRS_PC_W = 21;
   localparam int PCRS_UPPER_W = 5;
   localparam int PCRS_PTR_W = 5;
   localparam int PCRS_DEPTH = 31;
   localparam logic [PCRS_PTR_W-1:0] PCRS_PTR_MAX = 5'h1F;
   localparam logic [PCRS_PTR_W-1:0] PCRS_PTR_ONE = 5'h01;
   localparam logic [PCRS_PC_W-1:0] PCRS_PC_STEP = 21'h000002;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [PCRS_PC_W-1:0] PCRS_PC_RST = 21'h000000;
   localparam logic [7:0] PCRS_HIGH_LATCH_RST = 8'h00;
   localparam logic [PCRS_UPPER_W-1:0] PCRS_UPPER_LATCH_RST = 5'h00;
   localparam logic [PCRS_PTR_W-1:0] PCRS_PTR_RST = 5'h00;
   localparam logic [7:0] PCRS_RDATA_RST = 8'h00;

   // ---------------------------------------------------------------
   // Field positions of the stack status byte
   // ---------------------------------------------------------------
   localparam int PCRS_STAT_OVF_BIT = 0;
   localparam int PCRS_STAT_UNF_BIT = 1;

   // ---------------------------------------------------------------
   // Flow commands from the instruction sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PCRS_OP_NONE = 3'h0,
      PCRS_OP_NEXT = 3'h1,
      PCRS_OP_JUMP = 3'h2,
      PCRS_OP_CALL = 3'h3,
      PCRS_OP_INTACK = 3'h4,
      PCRS_OP_RETURN = 3'h5
   } pcrs_op_t;

   typedef struct packed {
      pcrs_op_t op;
      logic [PCRS_PC_W-1:0] target;
   } pcrs_cmd_t;

   // ---------------------------------------------------------------
   // Special-register selection for the core's access port
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      PCRS_SEL_NONE = 4'h0,
      PCRS_SEL_COUNTER_LOW = 4'h1,
      PCRS_SEL_HIGH_LATCH = 4'h2,
      PCRS_SEL_UPPER_LATCH = 4'h3,
      PCRS_SEL_STACK_POINTER = 4'h4,
      PCRS_SEL_TOS_LOW = 4'h5,
      PCRS_SEL_TOS_HIGH = 4'h6,
      PCRS_SEL_TOS_UPPER = 4'h7,
      PCRS_SEL_STATUS = 4'h8
   } pcrs_sel_t;

   typedef struct packed {
      pcrs_sel_t sel;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } pcrs_sfr_req_t;

   typedef struct packed {
      logic underflow;
      logic overflow;
   } pcrs_status_t;

   localparam pcrs_status_t PCRS_STATUS_RST = 2'h0;

   typedef struct packed {
      logic [PCRS_PC_W-1:0] program_counter;
      logic [7:0] high_latch;
      logic [PCRS_UPPER_W-1:0] upper_latch;
      logic [PCRS_PTR_W-1:0] stack_pointer;
      pcrs_status_t status;
      logic [7:0] sfr_rdata;
   } pcrs_state_t;

endpackage

// [hw/pcrs_stack_mem.sv]
// Return address storage: 31 entries of 21 bits behind a 5-bit index.
// Assumes the owner never writes index zero and reads index zero only
// as an empty stack; that index has no storage and reads as zero.

module pcrs_stack_mem
   import pcrs_pkg::*;
(
   // Clock
   input wire logic CLOCK,
   // Write port
   input wire logic WE,
   input wire logic [pcrs_pkg::PCRS_PTR_W-1:0] WADDR,
   input wire logic [pcrs_pkg::PCRS_PC_W-1:0] WDATA,
   // Read port, data one cycle after the address
   input wire logic [pcrs_pkg::PCRS_PTR_W-1:0] RADDR,
   output logic [pcrs_pkg::PCRS_PC_W-1:0] RDATA
);

   logic [PCRS_PC_W-1:0] mem [1:PCRS_DEPTH];

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Write-first: a read of the entry being written returns the new
   // word, so the owner's mirror of the top entry never goes stale.
   always_ff @(posedge CLOCK) begin
      if (WE && WADDR != PCRS_PTR_RST) begin // R12
         mem[WADDR] <= WDATA;
      end
      if (RADDR == PCRS_PTR_RST) begin // R15
         RDATA <= PCRS_PC_RST;
      end else if (WE && WADDR == RADDR) begin
         RDATA <= WDATA;
      end else begin
         RDATA <= mem[RADDR];
      end
   end

endmodule

// [hw/pcrs_core.sv]
// Program counter with its two latch bytes and the hardware return
// stack, including its pointer, top-of-stack access and status flags.
// Assumes the sequencer presents one flow command per cycle and that
// special-register accesses come from the same core clock domain.

module pcrs_core
   import pcrs_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_B,
   // Flow commands from the instruction sequencer
   input wire pcrs_pkg::pcrs_cmd_t CMD,
   // Special-register access from the core
   input wire pcrs_pkg::pcrs_sfr_req_t SFR_REQ,
   output logic [7:0] SFR_RDATA,
   // Fetch address and stack state
   output logic [pcrs_pkg::PCRS_PC_W-1:0] PROGRAM_COUNTER,
   output logic [pcrs_pkg::PCRS_PTR_W-1:0] STACK_POINTER,
   output pcrs_pkg::pcrs_status_t STACK_STATUS
);

   import pcrs_pkg::*;

   // ---------------------------------------------------------------
   // State and stack memory wiring
   // ---------------------------------------------------------------
   pcrs_state_t state;
   pcrs_state_t next_state;

   logic mem_we;
   logic [PCRS_PTR_W-1:0] mem_waddr;
   logic [PCRS_PC_W-1:0] mem_wdata;
   logic [PCRS_PC_W-1:0] top_entry;

   logic is_push;
   logic is_pop;
   logic push_ok;
   logic pop_ok;
   logic sw_write;
   logic sw_read;
   logic [PCRS_PC_W-1:0] return_address;
   logic [PCRS_PC_W-1:0] counter_after_seq;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   // Calls and interrupt acknowledges both push; every return flavour
   // pops the same way, so the sequencer folds them into one command.
   assign is_push = (CMD.op == PCRS_OP_CALL) ||
                    (CMD.op == PCRS_OP_INTACK); // R9
   assign is_pop = (CMD.op == PCRS_OP_RETURN); // R10
   assign push_ok = is_push && (state.stack_pointer != PCRS_PTR_MAX);
   assign pop_ok = is_pop && (state.stack_pointer != PCRS_PTR_RST);
   assign sw_write = SFR_REQ.wr;
   assign sw_read = SFR_REQ.rd;

   // The sequencer has already moved the counter past the call, so the
   // current value is the address of the following instruction.
   assign return_address = state.program_counter; // R13

   // ---------------------------------------------------------------
   // Flow path of the program counter
   // ---------------------------------------------------------------
   always_comb begin
      counter_after_seq = state.program_counter;
      case (CMD.op)
         PCRS_OP_NEXT: begin
            counter_after_seq = state.program_counter + PCRS_PC_STEP; // R7
         end
         PCRS_OP_JUMP, PCRS_OP_CALL, PCRS_OP_INTACK: begin
            // Direct loads bypass both latch bytes.
            counter_after_seq = CMD.target; // R8
         end
         PCRS_OP_RETURN: begin
            // top_entry already mirrors the entry the pointer selects;
            // an empty stack reads as zero.
            counter_after_seq = top_entry; // R14
         end
         PCRS_OP_NONE: begin
            counter_after_seq = state.program_counter;
         end
         default: begin
            counter_after_seq = state.program_counter;
         end
      endcase
      counter_after_seq[0] = 1'b0; // R6
   end

   // ---------------------------------------------------------------
   // Stack memory write port
   // ---------------------------------------------------------------
   // Only one write per cycle reaches the memory. A top-of-stack write
   // shares the port with a push; the push is taken when both arrive,
   // which cannot happen while interrupts are masked as they must be.
   always_comb begin
      mem_we = 1'b0;
      mem_waddr = state.stack_pointer;
      mem_wdata = top_entry;
      if (push_ok) begin
         mem_we = 1'b1;
         mem_waddr = state.stack_pointer + PCRS_PTR_ONE; // R13
         mem_wdata = return_address;
      end else if (sw_write &&
                   state.stack_pointer != PCRS_PTR_RST) begin // R15
         case (SFR_REQ.sel)
            PCRS_SEL_TOS_LOW: begin
               mem_we = 1'b1;
               mem_wdata[7:0] = SFR_REQ.wdata; // R18
            end
            PCRS_SEL_TOS_HIGH: begin
               mem_we = 1'b1;
               mem_wdata[15:8] = SFR_REQ.wdata; // R18
            end
            PCRS_SEL_TOS_UPPER: begin
               mem_we = 1'b1;
               mem_wdata[20:16] = SFR_REQ.wdata[4:0]; // R18
            end
            default: begin
               mem_we = 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;

      // Flow commands own the counter unless software writes the low
      // byte in the same cycle, which then replaces the whole counter.
      next_state.program_counter = counter_after_seq; // R11

      // Pointer movement and error flags from the sequencer.
      if (push_ok) begin
         next_state.stack_pointer = state.stack_pointer + PCRS_PTR_ONE;
      end else if (is_push) begin
         next_state.status.overflow = 1'b1; // R20
      end
      if (pop_ok) begin
         next_state.stack_pointer = state.stack_pointer - PCRS_PTR_ONE;
      end else if (is_pop) begin
         next_state.status.underflow = 1'b1; // R20
      end

      // Software writes.
      if (sw_write) begin
         case (SFR_REQ.sel)
            PCRS_SEL_COUNTER_LOW: begin
               next_state.program_counter = {state.upper_latch,
                                             state.high_latch,
                                             SFR_REQ.wdata[7:1],
                                             1'b0}; // R4
            end
            PCRS_SEL_HIGH_LATCH: begin
               next_state.high_latch = SFR_REQ.wdata; // R3
            end
            PCRS_SEL_UPPER_LATCH: begin
               next_state.upper_latch = SFR_REQ.wdata[4:0]; // R3
            end
            PCRS_SEL_STACK_POINTER: begin
               next_state.stack_pointer = SFR_REQ.wdata[4:0]; // R17
            end
            PCRS_SEL_STATUS: begin
               // Software may only clear a flag; a fault in the same
               // cycle keeps it set so the event is not lost.
               if (!SFR_REQ.wdata[PCRS_STAT_OVF_BIT] &&
                   !(is_push && !push_ok)) begin
                  next_state.status.overflow = 1'b0; // R16
               end
               if (!SFR_REQ.wdata[PCRS_STAT_UNF_BIT] &&
                   !(is_pop && !pop_ok)) begin
                  next_state.status.underflow = 1'b0; // R16
               end
            end
            default: begin
               next_state.status = next_state.status;
            end
         endcase
      end

      // Software reads: data appear in the cycle after the request.
      // Calls and returns never reach the latches.
      if (sw_read) begin
         case (SFR_REQ.sel)
            PCRS_SEL_COUNTER_LOW: begin
               next_state.sfr_rdata = state.program_counter[7:0]; // R2
               next_state.high_latch = state.program_counter[15:8]; // R5
               next_state.upper_latch = state.program_counter[20:16]; // R5
            end
            PCRS_SEL_HIGH_LATCH: begin
               next_state.sfr_rdata = state.high_latch;
            end
            PCRS_SEL_UPPER_LATCH: begin
               next_state.sfr_rdata = {3'h0, state.upper_latch};
            end
            PCRS_SEL_STACK_POINTER: begin
               next_state.sfr_rdata = {3'h0, state.stack_pointer}; // R17
            end
            PCRS_SEL_TOS_LOW: begin
               next_state.sfr_rdata = top_entry[7:0]; // R18
            end
            PCRS_SEL_TOS_HIGH: begin
               next_state.sfr_rdata = top_entry[15:8]; // R18
            end
            PCRS_SEL_TOS_UPPER: begin
               next_state.sfr_rdata = {3'h0, top_entry[20:16]}; // R18
            end
            PCRS_SEL_STATUS: begin
               next_state.sfr_rdata = {6'h00,
                                       state.status.underflow,
                                       state.status.overflow}; // R16
            end
            default: begin
               next_state.sfr_rdata = PCRS_RDATA_RST;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         state.program_counter <= PCRS_PC_RST;
         state.high_latch <= PCRS_HIGH_LATCH_RST;
         state.upper_latch <= PCRS_UPPER_LATCH_RST;
         state.stack_pointer <= PCRS_PTR_RST; // R15
         state.status <= PCRS_STATUS_RST;
         state.sfr_rdata <= PCRS_RDATA_RST;
      end else begin
         state <= next_state; // R1
      end
   end

   // ---------------------------------------------------------------
   // Return stack storage
   // ---------------------------------------------------------------
   // Reading at the next pointer keeps the registered read data equal
   // to the entry the pointer selects, so a pop needs no extra cycle.
   // During reset the read address is the reset pointer.
   pcrs_stack_mem u_stack_mem (
      .CLOCK(CLOCK),
      .WE(mem_we && RST_B),
      .WADDR(mem_waddr),
      .WDATA(mem_wdata),
      .RADDR(RST_B ? next_state.stack_pointer : PCRS_PTR_RST),
      .RDATA(top_entry)
   ); // R12

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign PROGRAM_COUNTER = state.program_counter;
   assign STACK_POINTER = state.stack_pointer;
   assign STACK_STATUS = state.status;
   assign SFR_RDATA = state.sfr_rdata;

endmodule

// [verif/pcrs_core_chk.sv]
// Concurrent checks on the ports of the program counter and stack.
// Assumes one core clock and the synchronous active-low reset.

module pcrs_core_chk
   import pcrs_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_B,
   // Inputs of the block
   input wire pcrs_pkg::pcrs_cmd_t CMD,
   input wire pcrs_pkg::pcrs_sfr_req_t SFR_REQ,
   // Outputs of the block
   input wire logic [7:0] SFR_RDATA,
   input wire logic [pcrs_pkg::PCRS_PC_W-1:0] PROGRAM_COUNTER,
   input wire logic [pcrs_pkg::PCRS_PTR_W-1:0] STACK_POINTER,
   input wire pcrs_pkg::pcrs_status_t STACK_STATUS
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------
   // Properties
   // ----------------------------------------------------------
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   chk_pc_aligned: assert property (PROGRAM_COUNTER[0] == 1'b0)
      else $error("counter bit zero set");
   chk_next_step: assert property (CMD.op == PCRS_OP_NEXT &&
      !SFR_REQ.wr |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 21'h2)
      else $error("sequential step wrong");
   chk_jump_load: assert property (CMD.op == PCRS_OP_JUMP &&
      !SFR_REQ.wr |=> PROGRAM_COUNTER == ($past(CMD.target) & 21'h1FFFFE))
      else $error("jump target not loaded");
   chk_push_ptr: assert property (CMD.op == PCRS_OP_CALL &&
      STACK_POINTER != PCRS_PTR_MAX && !SFR_REQ.wr
      |=> STACK_POINTER == $past(STACK_POINTER) + PCRS_PTR_ONE)
      else $error("push pointer wrong");
   chk_push_pop: assert property (CMD.op == PCRS_OP_INTACK &&
      STACK_POINTER != PCRS_PTR_MAX && !SFR_REQ.wr
      ##1 CMD.op == PCRS_OP_RETURN && !SFR_REQ.wr
      |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER, 2))
      else $error("pop after push wrong");
   chk_ovf_flag: assert property (CMD.op == PCRS_OP_CALL &&
      STACK_POINTER == PCRS_PTR_MAX && !SFR_REQ.wr
      |=> STACK_STATUS.overflow && STACK_POINTER == PCRS_PTR_MAX)
      else $error("overflow not flagged");
   chk_unf_flag: assert property (CMD.op == PCRS_OP_RETURN &&
      STACK_POINTER == 5'h00 && !SFR_REQ.wr |=> STACK_STATUS.underflow
      && STACK_POINTER == 5'h00 && PROGRAM_COUNTER == 21'h000000)
      else $error("underflow not flagged");
   chk_low_read: assert property (SFR_REQ.rd &&
      SFR_REQ.sel == PCRS_SEL_COUNTER_LOW
      |=> SFR_RDATA == 8'($past(PROGRAM_COUNTER)))
      else $error("low byte read wrong");
   chk_low_write: assert property (SFR_REQ.wr &&
      SFR_REQ.sel == PCRS_SEL_COUNTER_LOW
      |=> PROGRAM_COUNTER[7:0] == ($past(SFR_REQ.wdata) & 8'hFE))
      else $error("low byte write wrong");
   chk_ovf_sticky: assert property (STACK_STATUS.overflow &&
      !(SFR_REQ.wr && SFR_REQ.sel == PCRS_SEL_STATUS)
      |=> STACK_STATUS.overflow)
      else $error("overflow flag lost");
endmodule

// [verif/pcrs_seq_model.sv]
// Behavioural instruction sequencer feeding flow commands.
// Assumes its tasks are called from one bench process only.

module pcrs_seq_model
   import pcrs_pkg::*;
(
   // Clock
   input wire logic CLOCK,
   // Flow command to the block
   output pcrs_pkg::pcrs_cmd_t CMD
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------
   // Command driver
   // ----------------------------------------------------------
   initial CMD = '{PCRS_OP_NONE, 21'h000000};

   // Interrupt acks are never launched beside stack register access.
   task automatic issue(input pcrs_op_t op, input logic [20:0] t);
      @(posedge CLOCK);
      #1 CMD = '{op, t};
   endtask

   // The idle target is scrambled so a stale address is never trusted.
   task automatic idle();
      @(posedge CLOCK);
      #1 CMD = '{PCRS_OP_NONE, ~CMD.target};
   endtask
endmodule

// [verif/pcrs_core_tb.sv]
// Self-checking bench for the program counter and return stack.
// Assumes the package, core and checker are compiled before it.

module pcrs_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcrs_pkg::*;

   // ----------------------------------------------------------
   // Harness
   // ----------------------------------------------------------
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   pcrs_cmd_t cmd;
   pcrs_sfr_req_t req = '{PCRS_SEL_NONE, 1'b0, 1'b0, 8'h00};
   logic [7:0] rdata;
   logic [20:0] pc;
   logic [4:0] sp;
   pcrs_status_t st;
   int fails = 0;
   int check_count = 0;

   always #2 clock = ~clock;

   pcrs_seq_model seq (.CLOCK(clock), .CMD(cmd));
   pcrs_core dut (.CLOCK(clock), .RST_B(rst_b), .CMD(cmd), .SFR_REQ(req),
      .SFR_RDATA(rdata), .PROGRAM_COUNTER(pc), .STACK_POINTER(sp),
      .STACK_STATUS(st));

   task automatic chk(input logic [20:0] seen, exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t %s: %h not %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clock);
      #1 rst_b = 1'b0;
      repeat (6) @(posedge clock);
      #1 rst_b = 1'b1;
   endtask

   // One access held for one sampling edge; a read when w is low.
   task automatic sfr(input pcrs_sel_t s, input logic w,
                      input logic [7:0] d);
      @(posedge clock);
      #1 req = '{s, w, !w, d};
      @(posedge clock);
      #1 req = '{PCRS_SEL_NONE, 1'b0, 1'b0, ~d};
   endtask

   task automatic step(input pcrs_op_t op, input logic [20:0] t);
      seq.issue(op, t);
      seq.idle();
   endtask

   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_reset();
      chk(pc, 21'h0, "counter");
      chk(21'(sp), 21'h0, "pointer");
      chk(21'(st), 21'h0, "status");
      chk(21'(rdata), 21'h0, "read data");
   endtask

   task automatic t_latch();
      sfr(PCRS_SEL_HIGH_LATCH, 1'b1, 8'hA5);
      sfr(PCRS_SEL_UPPER_LATCH, 1'b1, 8'h1B);
      sfr(PCRS_SEL_COUNTER_LOW, 1'b1, 8'h37);
      chk(pc, 21'h1BA536, "low write");
      step(PCRS_OP_JUMP, 21'h0C3C5B);
      chk(pc, 21'h0C3C5A, "jump");
      for (int i = 1; i <= 3; i++) begin
         step(PCRS_OP_NEXT, 21'h1FFFFF);
         chk(pc, 21'h0C3C5A + 21'(2 * i), "next");
      end
      step(PCRS_OP_CALL, 21'h000100);
      step(PCRS_OP_RETURN, 21'h000000);
      chk(pc, 21'h0C3C60, "return");
      sfr(PCRS_SEL_COUNTER_LOW, 1'b1, 8'h10);
      chk(pc, 21'h1BA510, "latches kept");
      step(PCRS_OP_JUMP, 21'h0E6D22);
      sfr(PCRS_SEL_COUNTER_LOW, 1'b0, 8'h00);
      chk(21'(rdata), 21'h22, "low read");
      sfr(PCRS_SEL_COUNTER_LOW, 1'b1, 8'h44);
      chk(pc, 21'h0E6D44, "latches copied");
   endtask

   task automatic t_deep();
      step(PCRS_OP_JUMP, 21'h1A0400);
      for (int i = 1; i <= 31; i++) begin
         step(i[0] ? PCRS_OP_CALL : PCRS_OP_INTACK, 21'h1A0400 + 21'(4 * i));
         chk(21'(sp), 21'(i), "push");
      end
      sfr(PCRS_SEL_TOS_LOW, 1'b0, 8'h00);
      chk(21'(rdata), 21'h78, "top low");
      sfr(PCRS_SEL_TOS_HIGH, 1'b0, 8'h00);
      chk(21'(rdata), 21'h04, "top high");
      sfr(PCRS_SEL_TOS_UPPER, 1'b0, 8'h00);
      chk(21'(rdata), 21'h1A, "top upper");
      step(PCRS_OP_CALL, 21'h1A0800);
      chk(21'(sp), 21'h1F, "overflow pointer");
      chk(21'(st), 21'h1, "overflow flag");
      for (int i = 31; i >= 1; i--) begin
         step(PCRS_OP_RETURN, 21'h000000);
         chk(pc, 21'h1A0400 + 21'(4 * (i - 1)), "pop");
         chk(21'(sp), 21'(i - 1), "pop pointer");
      end
      step(PCRS_OP_RETURN, 21'h000000);
      chk(pc, 21'h0, "underflow counter");
      sfr(PCRS_SEL_STATUS, 1'b0, 8'h00);
      chk(21'(rdata), 21'h3, "status read");
      sfr(PCRS_SEL_STATUS, 1'b1, 8'h00);
      chk(21'(st), 21'h0, "status cleared");
   endtask

   task automatic t_swstack();
      sfr(PCRS_SEL_STACK_POINTER, 1'b1, 8'hE3);
      chk(21'(sp), 21'h3, "pointer write");
      sfr(PCRS_SEL_TOS_LOW, 1'b1, 8'h9A);
      sfr(PCRS_SEL_TOS_HIGH, 1'b1, 8'h5C);
      sfr(PCRS_SEL_TOS_UPPER, 1'b1, 8'h07);
      sfr(PCRS_SEL_TOS_HIGH, 1'b0, 8'h00);
      chk(21'(rdata), 21'h5C, "top readback");
      step(PCRS_OP_RETURN, 21'h000000);
      chk(pc, 21'h075C9A, "software entry");
      sfr(PCRS_SEL_STACK_POINTER, 1'b0, 8'h00);
      chk(21'(rdata), 21'h2, "pointer read");
      seq.issue(PCRS_OP_INTACK, 21'h000800);
      seq.issue(PCRS_OP_RETURN, 21'h000000);
      seq.idle();
      chk(pc, 21'h075C9A, "back to back");
      chk(21'(sp), 21'h2, "back to back pointer");
   endtask

   initial begin
      do_reset();
      t_reset();
      t_latch();
      t_deep();
      t_swstack();
      do_reset();
      t_reset();
      end_sim();
   end

   // A hang counts as a mismatch and closes the run.
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      end_sim();
   end
endmodule

bind pcrs_core pcrs_core_chk chk_i (
   .CLOCK(CLOCK), .RST_B(RST_B), .CMD(CMD), .SFR_REQ(SFR_REQ),
   .SFR_RDATA(SFR_RDATA), .PROGRAM_COUNTER(PROGRAM_COUNTER),
   .STACK_POINTER(STACK_POINTER), .STACK_STATUS(STACK_STATUS));
